// file: dm_addr_consts.svh
// constants for the data memory address modifier
`ifndef DM_ADDR_CONSTS_SVH
`define DM_ADDR_CONSTS_SVH
`define ROW_PTR_HIGH_ADDR 7'h7a
`define ROW_PTR_LOW_ADDR 7'h7b
`define INDEX_LOW_ADDR 7'h7c
`define GEN_PTR_HIGH_ADDR 7'h7d
`define GEN_PTR_LOW_ADDR 7'h7e
`define STATUS_WORD_ADDR 7'h7f
`define BANK_ADDR 7'h79
`define PTR_ENABLE_BIT 3
`define INDEX_ENABLE_BIT 0
`define DECIMAL_BIT 3
`define COMPARE_BIT 2
`define CARRY_BIT 1
`define ZERO_BIT 0
`define RF_ALIAS_BASE 7'h40
`define RF_CTRL_LAST 7'h3f
`define OFF_DMA_EN 6'h00
`define OFF_STACK 6'h01
`define OFF_CHIP_EN 6'h07
`define OFF_HSC_GATE 6'h11
`define OFF_HSC_OPEN 6'h12
`define OFF_RMC_WIDTH 6'h15
`define OFF_TM1_CARRY 6'h16
`define OFF_TM0_CARRY 6'h17
`define OFF_SER_WAIT 6'h18
`define OFF_LEVELS 6'h0f
`define OFF_SER_MODE 6'h08
`define OFF_TM2_CLK 6'h09
`define OFF_TM1_CLK 6'h0a
`define OFF_TM0_CLK 6'h0b
`define OFF_EDGE_SEL 6'h1f
`define OFF_ADC 6'h21
`define OFF_P1C_DIR 6'h27
`define OFF_IDC_EN 6'h31
`define OFF_IDC_PITCH 6'h32
`define OFF_P2A_DIR 6'h34
`define OFF_P1B_DIR 6'h35
`define OFF_P0B_DIR 6'h36
`define OFF_P0A_DIR 6'h37
`endif

// file: dm_addr_pkg.sv
// types for the data memory address modifier
package dm_addr_pkg;
   typedef enum logic [1:0] {
      OP_PLAIN,
      OP_IND_STORE,
      OP_IND_LOAD,
      OP_UNMODIFIED
   } op_kind_t;
endpackage

// file: data_memory_address_modifier.sv
// address modification, system flags and register file of the 4-bit core
`timescale 1ns/1ps
`include "dm_addr_consts.svh"

module data_memory_address_modifier #(
   parameter int BANK_W = 4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire dm_addr_pkg::op_kind_t opKind,
   input wire logic [3:0] directBank,
   input wire logic [6:0] directAddr,
   input wire logic [3:0] genRegColumn,
   input wire logic [3:0] genRegData,
   input wire logic sysWrite,
   input wire logic [6:0] sysWriteAddr,
   input wire logic [3:0] sysWriteData,
   input wire logic [3:0] aluFlags,
   input wire logic aluFlagsLoad,
   input wire logic peek,
   input wire logic poke,
   input wire logic [6:0] rfAddr,
   input wire logic [3:0] windowData,
   input wire logic [3:0] aliasReadData,
   input wire logic chipEnablePin,
   input wire logic vsyncPin,
   input wire logic remotePin,
   input wire logic timer1Tick,
   input wire logic timer0Tick,
   input wire logic adcCompare,
   output logic [BANK_W-1:0] dataBank,
   output logic [6:0] dataAddr,
   output logic [BANK_W-1:0] indBank,
   output logic [6:0] indAddr,
   output logic [3:0] genRegBank,
   output logic [6:0] genRegAddr,
   output logic [3:0] peekData,
   output logic peekValid,
   output logic aliasWrite,
   output logic [6:0] aliasAddr,
   output logic [3:0] aliasWriteData,
   output logic [3:0] statusWord,
   output logic [3:0] bankReg,
   output logic rowPointerEnable,
   output logic indexEnable,
   output logic [10:0] indexRegister,
   output logic [6:0] rowPointer,
   output logic [3:0] ctrlDmaEnable,
   output logic [3:0] ctrlStack,
   output logic [3:0] ctrlHscGate,
   output logic [3:0] ctrlHscOpen,
   output logic [3:0] ctrlRmcWidth,
   output logic [3:0] ctrlSerialMode,
   output logic [3:0] ctrlSerialWait,
   output logic [3:0] ctrlTm2Clock,
   output logic [3:0] ctrlTm1Clock,
   output logic [3:0] ctrlTm0Clock,
   output logic [3:0] ctrlEdgeSelect,
   output logic [2:0] ctrlAdcChannel,
   output logic [3:0] ctrlP1cDir,
   output logic [3:0] ctrlIdcEnable,
   output logic [3:0] ctrlIdcPitch,
   output logic [3:0] ctrlP2aDir,
   output logic [3:0] ctrlP1bDir,
   output logic [3:0] ctrlP0bDir,
   output logic [3:0] ctrlP0aDir
);

   // system register nibbles
   logic [2:0] index_high_part;
   logic [3:0] index_middle_nibble;
   logic [3:0] index_low_nibble;
   logic row_pointer_enable;
   logic [2:0] general_register_pointer_low;
   logic [4:0] program_status_word;
   logic [3:0] bank;
   logic timer1Carry;
   logic timer0Carry;

   assign rowPointerEnable = row_pointer_enable;
   assign indexEnable = program_status_word[`INDEX_ENABLE_BIT];
   // top bit of the shared field never stores anything
   assign indexRegister = {1'b0, index_high_part[1:0], index_middle_nibble, index_low_nibble};
   assign rowPointer = indexRegister[10:4];
   assign statusWord = program_status_word[3:0];
   assign bankReg = bank;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         row_pointer_enable <= 1'b0;
         index_high_part <= 3'h0;
      end else if (sysWrite && sysWriteAddr == `ROW_PTR_HIGH_ADDR) begin
         row_pointer_enable <= sysWriteData[`PTR_ENABLE_BIT];
         index_high_part <= {1'b0, sysWriteData[1:0]};
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         index_middle_nibble <= 4'h0;
         index_low_nibble <= 4'h0;
      end else if (sysWrite) begin
         if (sysWriteAddr == `ROW_PTR_LOW_ADDR)
            index_middle_nibble <= sysWriteData;
         if (sysWriteAddr == `INDEX_LOW_ADDR)
            index_low_nibble <= sysWriteData;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         general_register_pointer_low <= 3'h0;
      else if (sysWrite && sysWriteAddr == `GEN_PTR_LOW_ADDR)
         general_register_pointer_low <= sysWriteData[3:1];
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         bank <= 4'h0;
      else if (sysWrite && sysWriteAddr == `BANK_ADDR)
         bank <= {1'b0, sysWriteData[2:0]};
   end

   // software write wins over alu flag update in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         program_status_word <= 5'h00;
      end else if (sysWrite && sysWriteAddr == `STATUS_WORD_ADDR) begin
         program_status_word <= {1'b0, sysWriteData};
      end else if (aluFlagsLoad) begin
         program_status_word[2:1] <= aluFlags[2:1];
         program_status_word[0] <= program_status_word[0];
         program_status_word[3] <= program_status_word[3];
      end
   end

   // general register: bank zero, row from low pointer
   assign genRegBank = 4'h0;
   assign genRegAddr = {general_register_pointer_low, genRegColumn[3:0]} & 7'h7f;

   // address generation
   logic modifiable;
   assign modifiable = (opKind != dm_addr_pkg::OP_UNMODIFIED);

   always_comb begin
      dataBank = bank[BANK_W-1:0];
      dataAddr = directAddr;
      if (indexEnable && modifiable) begin
         // real address: bank/address OR index
         dataBank = bank[BANK_W-1:0] | BANK_W'({1'b0, indexRegister[10:7]});
         dataAddr = directAddr | indexRegister[6:0];
      end
      // indirect side: row of direct operand, or of row pointer when enabled, column from register
      indBank = dataBank;
      indAddr = {dataAddr[6:4], genRegData};
      if (indexEnable && modifiable) begin
         indBank = bank[BANK_W-1:0] | BANK_W'({1'b0, indexRegister[10:7]});
         indAddr = {directAddr[6:4] | indexRegister[6:4], genRegData};
      end
      if (row_pointer_enable && (opKind == dm_addr_pkg::OP_IND_STORE || opKind == dm_addr_pkg::OP_IND_LOAD)) begin
         indBank = BANK_W'(rowPointer[6:3]);
         indAddr = {rowPointer[2:0], genRegData};
      end
   end

   // control register file, 00h..3fh
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrlDmaEnable <= 4'h0;
         ctrlStack <= 4'h0;
         ctrlHscGate <= 4'h0;
         ctrlHscOpen <= 4'h0;
         ctrlRmcWidth <= 4'h0;
         ctrlSerialMode <= 4'h0;
         ctrlSerialWait <= 4'h0;
         ctrlTm2Clock <= 4'h0;
         ctrlTm1Clock <= 4'h0;
         ctrlTm0Clock <= 4'h0;
         ctrlEdgeSelect <= 4'h0;
         ctrlAdcChannel <= 3'h0;
         ctrlP1cDir <= 4'h0;
         ctrlIdcEnable <= 4'h0;
         ctrlIdcPitch <= 4'h0;
         ctrlP2aDir <= 4'h0;
         ctrlP1bDir <= 4'h0;
         ctrlP0bDir <= 4'h0;
         ctrlP0aDir <= 4'h0;
      end else if (poke && rfAddr <= `RF_CTRL_LAST) begin
         // only implemented bits are kept
         unique case (rfAddr[5:0])
            `OFF_DMA_EN: ctrlDmaEnable <= windowData & 4'h2;
            `OFF_STACK: ctrlStack <= windowData;
            `OFF_HSC_GATE: ctrlHscGate <= windowData & 4'h3;
            `OFF_HSC_OPEN: ctrlHscOpen <= windowData & 4'h8;
            `OFF_RMC_WIDTH: ctrlRmcWidth <= windowData & 4'h7;
            `OFF_SER_MODE: ctrlSerialMode <= windowData;
            `OFF_SER_WAIT: ctrlSerialWait <= windowData;
            `OFF_TM2_CLK: ctrlTm2Clock <= windowData;
            `OFF_TM1_CLK: ctrlTm1Clock <= windowData;
            `OFF_TM0_CLK: ctrlTm0Clock <= windowData;
            `OFF_EDGE_SEL: ctrlEdgeSelect <= windowData & 4'h5;
            `OFF_ADC: ctrlAdcChannel <= windowData[3:1];
            `OFF_P1C_DIR: ctrlP1cDir <= windowData & 4'h1;
            `OFF_IDC_EN: ctrlIdcEnable <= windowData & 4'h1;
            `OFF_IDC_PITCH: ctrlIdcPitch <= windowData & 4'h1;
            `OFF_P2A_DIR: ctrlP2aDir <= windowData;
            `OFF_P1B_DIR: ctrlP1bDir <= windowData;
            `OFF_P0B_DIR: ctrlP0bDir <= windowData;
            `OFF_P0A_DIR: ctrlP0aDir <= windowData;
            default: ;
         endcase
      end
   end

   // carry flags: set by timer, cleared by read; set wins
   logic peekCtrl;
   assign peekCtrl = peek && rfAddr <= `RF_CTRL_LAST;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         timer1Carry <= 1'b0;
         timer0Carry <= 1'b0;
      end else begin
         if (timer1Tick)
            timer1Carry <= 1'b1;
         else if (peekCtrl && rfAddr[5:0] == `OFF_TM1_CARRY)
            timer1Carry <= 1'b0;
         if (timer0Tick)
            timer0Carry <= 1'b1;
         else if (peekCtrl && rfAddr[5:0] == `OFF_TM0_CARRY)
            timer0Carry <= 1'b0;
      end
   end

   logic [3:0] ctrlRead;
   always_comb begin
      unique case (rfAddr[5:0])
         `OFF_DMA_EN: ctrlRead = ctrlDmaEnable;
         `OFF_STACK: ctrlRead = ctrlStack;
         `OFF_CHIP_EN: ctrlRead = {3'h0, chipEnablePin};
         `OFF_HSC_GATE: ctrlRead = ctrlHscGate;
         `OFF_HSC_OPEN: ctrlRead = ctrlHscOpen;
         `OFF_RMC_WIDTH: ctrlRead = ctrlRmcWidth;
         `OFF_TM1_CARRY: ctrlRead = {3'h0, timer1Carry};
         `OFF_TM0_CARRY: ctrlRead = {3'h0, timer0Carry};
         `OFF_SER_MODE: ctrlRead = ctrlSerialMode;
         `OFF_SER_WAIT: ctrlRead = ctrlSerialWait;
         `OFF_TM2_CLK: ctrlRead = ctrlTm2Clock;
         `OFF_TM1_CLK: ctrlRead = ctrlTm1Clock;
         `OFF_TM0_CLK: ctrlRead = ctrlTm0Clock;
         `OFF_LEVELS: ctrlRead = {1'b0, vsyncPin, 1'b0, remotePin};
         `OFF_EDGE_SEL: ctrlRead = ctrlEdgeSelect;
         `OFF_ADC: ctrlRead = {ctrlAdcChannel, adcCompare};
         `OFF_P1C_DIR: ctrlRead = ctrlP1cDir;
         `OFF_IDC_EN: ctrlRead = ctrlIdcEnable;
         `OFF_IDC_PITCH: ctrlRead = ctrlIdcPitch;
         `OFF_P2A_DIR: ctrlRead = ctrlP2aDir;
         `OFF_P1B_DIR: ctrlRead = ctrlP1bDir;
         `OFF_P0B_DIR: ctrlRead = ctrlP0bDir;
         `OFF_P0A_DIR: ctrlRead = ctrlP0aDir;
         default: ctrlRead = 4'h0;
      endcase
   end

   // peek answer one cycle later, from a flop
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         peekData <= 4'h0;
         peekValid <= 1'b0;
      end else begin
         peekValid <= peek;
         if (peek)
            peekData <= (rfAddr <= `RF_CTRL_LAST) ? ctrlRead : aliasReadData;
      end
   end

   // upper half aliases the current bank's 40h..7fh
   assign aliasAddr = rfAddr | `RF_ALIAS_BASE;
   assign aliasWrite = poke && rfAddr >= `RF_ALIAS_BASE;
   assign aliasWriteData = windowData;

endmodule

// file: dm_addr_chk.sv
// concurrent checks on the address modifier's ports
`timescale 1ns/1ps
module dm_addr_chk #(
   parameter int BANK_W = 4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire dm_addr_pkg::op_kind_t opKind,
   input wire logic [6:0] directAddr,
   input wire logic [3:0] genRegColumn,
   input wire logic [3:0] genRegData,
   input wire logic peek,
   input wire logic poke,
   input wire logic [6:0] rfAddr,
   input wire logic [3:0] windowData,
   input wire logic [BANK_W-1:0] dataBank,
   input wire logic [6:0] dataAddr,
   input wire logic [BANK_W-1:0] indBank,
   input wire logic [6:0] indAddr,
   input wire logic [3:0] genRegBank,
   input wire logic [6:0] genRegAddr,
   input wire logic peekValid,
   input wire logic aliasWrite,
   input wire logic [6:0] aliasAddr,
   input wire logic [3:0] aliasWriteData,
   input wire logic [3:0] statusWord,
   input wire logic [3:0] bankReg,
   input wire logic rowPointerEnable,
   input wire logic indexEnable,
   input wire logic [10:0] indexRegister,
   input wire logic [6:0] rowPointer
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic indOp;
   assign indOp = opKind == dm_addr_pkg::OP_IND_STORE || opKind == dm_addr_pkg::OP_IND_LOAD;
   AST_NO_MOD:
   assert property (!indexEnable |-> dataAddr == directAddr && dataBank == BANK_W'(bankReg))
      else $error("direct address changed outside index mode");
   AST_IND_SAME_ROW:
   assert property (!rowPointerEnable && !indexEnable && indOp
      |-> indAddr == {directAddr[6:4], genRegData} && indBank == BANK_W'(bankReg))
      else $error("indirect address not on operand row");
   AST_PTR_ROW:
   assert property (rowPointerEnable && indOp
      |-> indAddr == {rowPointer[2:0], genRegData} && indBank == BANK_W'(rowPointer[6:3]))
      else $error("indirect address not from row pointer");
   AST_INDEX_OR:
   assert property (indexEnable && opKind != dm_addr_pkg::OP_UNMODIFIED |-> dataAddr == (directAddr | indexRegister[6:0])
      && dataBank == BANK_W'(bankReg | indexRegister[10:7]))
      else $error("real address is not the OR with index");
   AST_UNMOD:
   assert property (opKind == dm_addr_pkg::OP_UNMODIFIED |-> dataAddr == directAddr)
      else $error("exempt instruction was modified");
   AST_SHARED:
   assert property (rowPointer == indexRegister[10:4] && !indexRegister[10])
      else $error("row pointer and index disagree");
   AST_IX_FLAG:
   assert property (indexEnable == statusWord[0])
      else $error("index enable not in status word");
   AST_GEN_BANK:
   assert property (genRegBank == 4'h0 && genRegAddr[3:0] == genRegColumn)
      else $error("general register outside bank zero");
   AST_ALIAS:
   assert property (poke |-> aliasWrite == rfAddr[6]
      && (!rfAddr[6] || (aliasAddr == rfAddr && aliasWriteData == windowData)))
      else $error("alias write wrong");
   AST_PEEK_VALID:
   assert property (peek |=> peekValid)
      else $error("peek gave no answer");
   AST_PEEK_IDLE:
   assert property (!peek |=> !peekValid)
      else $error("answer without peek");
endmodule
bind data_memory_address_modifier dm_addr_chk #(.BANK_W(BANK_W)) chk (.clock(clock), .rstn(rstn),
   .opKind(opKind), .directAddr(directAddr), .genRegColumn(genRegColumn), .genRegData(genRegData),
   .peek(peek), .poke(poke), .rfAddr(rfAddr), .windowData(windowData), .dataBank(dataBank),
   .dataAddr(dataAddr), .indBank(indBank), .indAddr(indAddr), .genRegBank(genRegBank),
   .genRegAddr(genRegAddr), .peekValid(peekValid), .aliasWrite(aliasWrite), .aliasAddr(aliasAddr),
   .aliasWriteData(aliasWriteData), .statusWord(statusWord), .bankReg(bankReg),
   .rowPointerEnable(rowPointerEnable), .indexEnable(indexEnable), .indexRegister(indexRegister),
   .rowPointer(rowPointer));

// file: data_memory_model.sv
// behavioural data memory behind the alias window
`timescale 1ns/1ps
module data_memory_model (
   input wire logic clock,
   input wire logic aliasWrite,
   input wire logic [6:0] aliasAddr,
   input wire logic [3:0] aliasWriteData,
   output logic [3:0] aliasReadData
);
   // one bank only: the bench keeps the bank fixed around alias traffic
   logic [3:0] mem [0:127];
   always_ff @(posedge clock) begin
      if (aliasWrite) begin
         mem[aliasAddr] <= aliasWriteData;
      end
   end
   assign aliasReadData = mem[aliasAddr];
endmodule

// file: tb.sv
// self-checking bench for the data memory address modifier
`timescale 1ns/1ps
`include "dm_addr_consts.svh"
module tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   dm_addr_pkg::op_kind_t opKind = dm_addr_pkg::OP_PLAIN;
   logic [6:0] directAddr = 7'h00, sysWriteAddr = 7'h00, rfAddr = 7'h00;
   logic [3:0] genRegColumn = 4'h5, genRegData = 4'h0, sysWriteData = 4'h0, aluFlags = 4'h0, windowData = 4'h0;
   logic sysWrite = 1'b0, aluFlagsLoad = 1'b0, peek = 1'b0, poke = 1'b0, chipEnablePin = 1'b1, timer1Tick = 1'b0;
   logic [3:0] dataBank, indBank, genRegBank, peekData, aliasWriteData, statusWord, ctrlP1bDir, aliasReadData;
   logic [6:0] dataAddr, indAddr, genRegAddr, aliasAddr, rowPointer;
   logic peekValid, aliasWrite, rowPointerEnable, indexEnable;
   logic [10:0] indexRegister;
   logic [59:0] r;
   int nMismatch = 0;
   int checksDone = 0;
   // bank,ptrHigh,ptrLow,idxLow,status,op | addr,reg | expBank,expAddr | expIndBank,expIndAddr
   logic [59:0] rows [0:8] = '{60'h000001_348_034_038, 60'h100002_34e_134_13e, 60'h085001_348_034_058,
      60'h085000_348_034_000, 60'h095002_348_034_258, 60'h000210_118_013_000, 60'h000213_118_011_000,
      60'h010010_058_205_000, 60'h085211_118_053_058};
   always #4 clock = ~clock;
   data_memory_address_modifier DUT (
      .clock(clock), .rstn(rstn), .opKind(opKind), .directBank(4'h0), .directAddr(directAddr),
      .genRegColumn(genRegColumn), .genRegData(genRegData), .sysWrite(sysWrite), .sysWriteAddr(sysWriteAddr),
      .sysWriteData(sysWriteData), .aluFlags(aluFlags), .aluFlagsLoad(aluFlagsLoad), .peek(peek), .poke(poke),
      .rfAddr(rfAddr), .windowData(windowData), .aliasReadData(aliasReadData), .chipEnablePin(chipEnablePin),
      .vsyncPin(1'b0), .remotePin(1'b0), .timer1Tick(timer1Tick), .timer0Tick(1'b0), .adcCompare(1'b0),
      .dataBank(dataBank), .dataAddr(dataAddr), .indBank(indBank), .indAddr(indAddr), .genRegBank(genRegBank),
      .genRegAddr(genRegAddr), .peekData(peekData), .peekValid(peekValid), .aliasWrite(aliasWrite),
      .aliasAddr(aliasAddr), .aliasWriteData(aliasWriteData), .statusWord(statusWord), .bankReg(),
      .rowPointerEnable(rowPointerEnable), .indexEnable(indexEnable), .indexRegister(indexRegister),
      .rowPointer(rowPointer), .ctrlDmaEnable(), .ctrlStack(), .ctrlHscGate(), .ctrlHscOpen(), .ctrlRmcWidth(),
      .ctrlSerialMode(), .ctrlSerialWait(), .ctrlTm2Clock(), .ctrlTm1Clock(), .ctrlTm0Clock(), .ctrlEdgeSelect(),
      .ctrlAdcChannel(), .ctrlP1cDir(), .ctrlIdcEnable(), .ctrlIdcPitch(), .ctrlP2aDir(),
      .ctrlP1bDir(ctrlP1bDir), .ctrlP0bDir(), .ctrlP0aDir());
   data_memory_model partner (.clock(clock), .aliasWrite(aliasWrite), .aliasAddr(aliasAddr),
      .aliasWriteData(aliasWriteData), .aliasReadData(aliasReadData));
   task automatic cmpVal(input logic [10:0] got, input logic [10:0] exp, input string what);
      checksDone++;
      if (got !== exp) begin
         nMismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // k: 0 system write, 1 poke, 2 peek; outputs settled on return
   task automatic req(input int k, input logic [6:0] a, input logic [3:0] d);
      @(posedge clock);
      sysWriteAddr <= a;
      sysWriteData <= d;
      rfAddr <= a;
      windowData <= d;
      sysWrite <= k == 0;
      poke <= k == 1;
      peek <= k == 2;
      @(posedge clock);
      sysWrite <= 1'b0;
      poke <= 1'b0;
      peek <= 1'b0;
      #1;
   endtask
   task automatic wrapUp;
      if (nMismatch == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (1000) @(posedge clock);
      nMismatch++;
      wrapUp;
   end
   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         r = rows[i];
         req(0, `BANK_ADDR, r[59:56]);
         req(0, `ROW_PTR_HIGH_ADDR, r[55:52]);
         req(0, `ROW_PTR_LOW_ADDR, r[51:48]);
         req(0, `INDEX_LOW_ADDR, r[47:44]);
         req(0, `STATUS_WORD_ADDR, r[43:40]);
         @(posedge clock);
         opKind <= dm_addr_pkg::op_kind_t'(r[37:36]);
         directAddr <= r[34:28];
         genRegData <= r[27:24];
         @(posedge clock);
         #1;
         cmpVal(dataBank, r[23:20], "data bank");
         cmpVal(dataAddr, r[18:12], "data addr");
         if (r[37] ^ r[36]) begin
            cmpVal(indBank, r[11:8], "ind bank");
            cmpVal(indAddr, r[6:0], "ind addr");
         end
         cmpVal(rowPointer, {1'b0, r[53:52], r[51:48]}, "row pointer");
         cmpVal(rowPointerEnable, r[55], "pointer enable");
         cmpVal(indexEnable, r[40], "index enable");
      end
      req(0, `GEN_PTR_LOW_ADDR, 4'he);
      cmpVal(genRegAddr, 7'h75, "gen reg addr");
      req(0, `ROW_PTR_HIGH_ADDR, 4'hf);
      cmpVal(indexRegister[10:8], 3'h3, "index high");
      req(0, `STATUS_WORD_ADDR, 4'h0);
      @(posedge clock);
      aluFlags <= 4'hf;
      aluFlagsLoad <= 1'b1;
      @(posedge clock);
      aluFlagsLoad <= 1'b0;
      #1;
      cmpVal(statusWord, 4'h6, "alu flags");
      req(1, 7'h35, 4'ha);
      cmpVal(ctrlP1bDir, 4'ha, "port dir");
      req(2, 7'h35, 4'h0);
      cmpVal(peekData, 4'ha, "peek port dir");
      req(1, 7'h11, 4'hf);
      req(2, 7'h11, 4'h0);
      cmpVal(peekData, 4'h3, "gate bits");
      req(1, 7'h07, 4'hf);
      req(2, 7'h07, 4'h0);
      cmpVal(peekData, 4'h1, "pin level");
      req(1, 7'h1f, 4'hf);
      req(2, 7'h1f, 4'h0);
      cmpVal(peekData, 4'h5, "edge select bits");
      req(2, 7'h0f, 4'h0);
      cmpVal(peekData, 4'h0, "sync levels");
      req(1, 7'h45, 4'h9);
      req(2, 7'h45, 4'h0);
      cmpVal(peekData, 4'h9, "alias");
      @(posedge clock);
      timer1Tick <= 1'b1;
      @(posedge clock);
      timer1Tick <= 1'b0;
      req(2, 7'h16, 4'h0);
      cmpVal(peekData, 4'h1, "carry set");
      req(2, 7'h16, 4'h0);
      cmpVal(peekData, 4'h0, "carry cleared by read");
      wrapUp;
   end
endmodule
